// *** bench/rafo_chk_sva.sv ***
// Port assertions for the alarm / frequency-output block.
// Assumes one clock domain; bound into every rafo_alarm_freq.
`timescale 1ns/10ps
module rafo_chk
	import rafo_pkg::*;
(
	input wire logic i_sys_clk,
	input wire logic i_rst,
	input wire rafo_reg_sel_t i_reg_sel,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic [23:0] i_reg_wdata,
	input wire logic i_minute_tick,
	input wire logic [23:0] o_reg_rdata,
	input wire logic o_irq_pin_o,
	input wire logic o_irq_pin_oe,
	input wire logic [7:0] o_rate_trim,
	input wire logic o_preset_stb
);
	wire logic rd1 = i_reg_rd && i_reg_sel == RAFO_SEL_STATUS1;
	wire logic rdb = i_reg_rd && (i_reg_sel == RAFO_SEL_TRIM || i_reg_sel == RAFO_SEL_SCRATCH);
	wire logic [7:0] wlo = i_reg_wdata[7:0];
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_rst);
	property p_por_stb;
		$fell(i_rst) |-> o_preset_stb ##1 !o_preset_stb;
	endproperty
	a_por_stb: assert property (p_por_stb) else $error("preset strobe");
	property p_por_quiet;
		$fell(i_rst) |-> o_reg_rdata == 24'h000000 && !o_irq_pin_oe;
	endproperty
	a_por_quiet: assert property (p_por_quiet) else $error("reset outputs");
	property p_st1_rd;
		rd1 |=> o_reg_rdata[23:7] == 17'h00000;
	endproperty
	a_st1_rd: assert property (p_st1_rd) else $error("status1 upper bits");
	property p_byte_rd;
		rdb |=> o_reg_rdata[23:8] == 16'h0000;
	endproperty
	a_byte_rd: assert property (p_byte_rd) else $error("byte read upper bits");
	property p_rd_hold;
		!i_reg_rd |=> $stable(o_reg_rdata);
	endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
	property p_pin_o;
		o_irq_pin_o == 1'b0;
	endproperty
	a_pin_o: assert property (p_pin_o) else $error("pin level");
	property p_trim;
		i_reg_wr && i_reg_sel == RAFO_SEL_TRIM |=> o_rate_trim == $past(wlo);
	endproperty
	a_trim: assert property (p_trim) else $error("trim byte");
	property p_mode_off;
		i_reg_wr && i_reg_sel == RAFO_SEL_STATUS2 && wlo == 8'h00 |=> ##1 !o_irq_pin_oe;
	endproperty
	a_mode_off: assert property (p_mode_off) else $error("pin not released");
	property p_rd_clr;
		rd1 && !i_minute_tick ##1 !i_minute_tick ##1 rd1 && !i_minute_tick
			|=> o_reg_rdata[3:0] == 4'h0;
	endproperty
	a_rd_clr: assert property (p_rd_clr) else $error("flags not cleared");
	property p_init_stb;
		i_reg_wr && i_reg_sel == RAFO_SEL_STATUS1 && i_reg_wdata[7] |=> o_preset_stb;
	endproperty
	a_init_stb: assert property (p_init_stb) else $error("init strobe");
endmodule
bind rafo_alarm_freq rafo_chk i_rafo_chk (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
	.i_reg_sel(i_reg_sel), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
	.i_reg_wdata(i_reg_wdata), .i_minute_tick(i_minute_tick), .o_reg_rdata(o_reg_rdata),
	.o_irq_pin_o(o_irq_pin_o), .o_irq_pin_oe(o_irq_pin_oe), .o_rate_trim(o_rate_trim),
	.o_preset_stb(o_preset_stb));

// *** bench/rafo_host_model.sv ***
// Host side of the register port: single-cycle reads and writes.
// Assumes read data arrives one cycle after the read edge.
`timescale 1ns/10ps
module rafo_host_model
	import rafo_pkg::*;
(
	input wire logic i_sys_clk,
	input wire logic [23:0] i_reg_rdata,
	output rafo_reg_sel_t o_reg_sel,
	output logic o_reg_wr,
	output logic o_reg_rd,
	output logic [23:0] o_reg_wdata
);
	initial begin
		o_reg_sel = RAFO_SEL_SCRATCH;
		o_reg_wr = 1'b0;
		o_reg_rd = 1'b0;
		o_reg_wdata = 24'h000000;
	end
	// Callers pass real BCD only, hour in the chosen 12/24 format, trim 5Ah or 00h
	task automatic wr(input rafo_reg_sel_t s, input logic [23:0] d);
		@(posedge i_sys_clk);
		#1;
		o_reg_sel = s;
		o_reg_wdata = d;
		o_reg_wr = 1'b1;
		@(posedge i_sys_clk);
		#1;
		o_reg_wr = 1'b0;
		// Idle data inverted so a stale word cannot pass as valid
		o_reg_wdata = ~d;
	endtask
	task automatic rd(input rafo_reg_sel_t s, output logic [23:0] d);
		@(posedge i_sys_clk);
		#1;
		o_reg_sel = s;
		o_reg_rd = 1'b1;
		@(posedge i_sys_clk);
		#1;
		o_reg_rd = 1'b0;
		d = i_reg_rdata;
	endtask
endmodule

// *** bench/tb.sv ***
// Self-checking bench for the alarm / frequency-output block.
// Assumes the host model on the register port; calendar and oscillator come from here.
`timescale 1ns/10ps
`include "rafo_cfg.svh"
module tb
	import rafo_pkg::*;
;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic osc = 1'b0;
	logic [23:0] now = 24'h000000;
	logic mtick = 1'b0;
	rafo_reg_sel_t sel;
	logic wr_s, rd_s, oe, h24;
	logic stick;
	logic stick_seen = 1'b0;
	logic [23:0] wd, rdata;
	logic [7:0] trim;
	logic [55:0] ptime;
	int n_errors = 0;
	int check_count = 0;
	always #2.5 clk = ~clk;
	// Offset keeps oscillator edges clear of the system clock edges
	initial #1.3 forever #62.5 osc = ~osc;
	// No full second passes in this short run, so any tick is early
	always @(posedge clk) begin
		if (stick === 1'b1) begin
			stick_seen <= 1'b1;
		end
	end
	rafo_alarm_freq i_rafo_alarm_freq (.i_sys_clk(clk), .i_rst(rst), .i_osc_clk(osc),
		.i_reg_sel(sel), .i_reg_wr(wr_s), .i_reg_rd(rd_s), .i_reg_wdata(wd),
		.i_now_wkhm(now), .i_minute_tick(mtick), .o_reg_rdata(rdata), .o_irq_pin_o(),
		.o_irq_pin_oe(oe), .o_second_tick(stick), .o_hour24(h24), .o_rate_trim(trim),
		.o_preset_stb(), .o_preset_time(ptime));
	rafo_host_model i_rafo_host_model (.i_sys_clk(clk), .i_reg_rdata(rdata),
		.o_reg_sel(sel), .o_reg_wr(wr_s), .o_reg_rd(rd_s), .o_reg_wdata(wd));
	task automatic chk(input logic [55:0] got, input logic [55:0] exp);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input rafo_reg_sel_t s, input logic [23:0] d);
		i_rafo_host_model.wr(s, d);
	endtask
	task automatic rd_chk(input rafo_reg_sel_t s, input logic [23:0] e);
		logic [23:0] v;
		i_rafo_host_model.rd(s, v);
		chk(v, e);
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic tick(input logic [23:0] t);
		now = t;
		mtick = 1'b1;
		cyc(1);
		mtick = 1'b0;
		cyc(2);
	endtask
	task automatic wait_oe(input logic v, output int n);
		n = 0;
		while (oe !== v && n < 30000) begin
			cyc(1);
			n++;
		end
	endtask
	task automatic t_por;
		rd_chk(RAFO_SEL_STATUS1, 24'h000001);
		rd_chk(RAFO_SEL_STATUS1, 24'h000000);
		chk(oe, 1'b1);
		rd_chk(RAFO_SEL_STATUS2, 24'h000080);
		rd_chk(RAFO_SEL_ALARM1, 24'h800000);
		rd_chk(RAFO_SEL_ALARM2, 24'h000000);
		rd_chk(RAFO_SEL_TRIM, 24'h000000);
		rd_chk(RAFO_SEL_SCRATCH, 24'h000000);
		chk(ptime, `RAFO_RT_DEFAULT);
		$display("por done");
	endtask
	task automatic t_init;
		wr(RAFO_SEL_STATUS1, 24'h0000C0);
		rd_chk(RAFO_SEL_STATUS1, 24'h000040);
		rd_chk(RAFO_SEL_STATUS2, 24'h000000);
		rd_chk(RAFO_SEL_ALARM1, 24'h000000);
		chk(oe, 1'b0);
		chk(h24, 1'b1);
		$display("init done");
	endtask
	task automatic t_bytes;
		wr(RAFO_SEL_TRIM, 24'h00005A);
		chk(trim, 8'h5A);
		wr(RAFO_SEL_TRIM, 24'h000000);
		wr(RAFO_SEL_SCRATCH, 24'hFFFFA5);
		rd_chk(RAFO_SEL_SCRATCH, 24'h0000A5);
		rd_chk(RAFO_SEL_TRIM, 24'h000000);
		rd_chk(rafo_reg_sel_t'(3'h6), 24'h000000);
		chk(trim, 8'h00);
		$display("bytes done");
	endtask
	task automatic t_alarm1;
		wr(RAFO_SEL_STATUS2, 24'h000020);
		wr(RAFO_SEL_ALARM1, 24'h409B01);
		rd_chk(RAFO_SEL_ALARM1, 24'h409B01);
		tick(24'h209A02);
		chk(oe, 1'b0);
		tick(24'h209A00);
		chk(oe, 1'b1);
		cyc(40);
		chk(oe, 1'b1);
		rd_chk(RAFO_SEL_STATUS1, 24'h000048);
		rd_chk(RAFO_SEL_STATUS1, 24'h000040);
		wr(RAFO_SEL_STATUS2, 24'h000000);
		cyc(1);
		chk(oe, 1'b0);
		$display("alarm1 done");
	endtask
	task automatic t_alarm2;
		wr(RAFO_SEL_STATUS2, 24'h000012);
		tick(24'h000000);
		chk(oe, 1'b0);
		wr(RAFO_SEL_ALARM2, 24'h000081);
		rd_chk(RAFO_SEL_ALARM2, 24'h000081);
		tick(24'h000080);
		chk(oe, 1'b1);
		rd_chk(RAFO_SEL_STATUS1, 24'h000044);
		wr(RAFO_SEL_STATUS2, 24'h000000);
		cyc(1);
		chk(oe, 1'b0);
		$display("alarm2 done");
	endtask
	task automatic t_freq;
		int n;
		wr(RAFO_SEL_STATUS2, 24'h000080);
		wr(RAFO_SEL_ALARM1, 24'h0F0000);
		rd_chk(RAFO_SEL_ALARM1, 24'h0F0000);
		wait_oe(1'b1, n);
		wait_oe(1'b0, n);
		wait_oe(1'b1, n);
		// One tap half period is 1024 oscillator cycles, 25600 system cycles
		chk(n > 25500 && n < 25700, 1'b1);
		chk(stick_seen, 1'b0);
		$display("freq done");
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge clk);
		#1;
		rst = 1'b0;
		t_por();
		t_init();
		t_bytes();
		t_alarm1();
		t_alarm2();
		t_freq();
		wrap_up();
	end
	initial begin
		#350000;
		n_errors++;
		wrap_up();
	end
endmodule

// *** verilog/rafo_alarm_freq.sv ***
// Alarm compare, frequency output and power-on register defaults of an
// RTC, with its status, alarm, trim and scratch registers.
// Assumes a command decoder on i_sys_clk gives register accesses, and a
// calendar on i_sys_clk gives the current weekday/hour/minute and a
// one-cycle minute tick. i_rst is the power-on detector.
`timescale 1ns/10ps
`include "rafo_cfg.svh"

module rafo_alarm_freq
	import rafo_pkg::*;
#(
	parameter logic [19:0] FREQ_TAPS = `RAFO_FREQ_TAPS
) (
	input wire logic i_sys_clk,
	input wire logic i_rst,
	input wire logic i_osc_clk,
	input wire rafo_reg_sel_t i_reg_sel,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic [23:0] i_reg_wdata,
	input wire logic [23:0] i_now_wkhm,
	input wire logic i_minute_tick,
	output logic [23:0] o_reg_rdata,
	output logic o_irq_pin_o,
	output logic o_irq_pin_oe,
	output logic o_second_tick,
	output logic o_hour24,
	output logic [7:0] o_rate_trim,
	output logic o_preset_stb,
	output logic [55:0] o_preset_time
);

	localparam int NFREQ = `RAFO_FSEL_HI - `RAFO_FSEL_LO + 1;
	localparam int PW = `RAFO_PRESC_W;

	// Oscillator synchroniser and prescaler
	logic osc_s1_r, osc_s2_r, osc_s3_r;
	logic [PW-1:0] presc_r, presc_nxt;
	logic sec_tick_r, sec_tick_nxt;

	// Registers
	logic pwrup_r, pwrup_nxt;
	logic a1_hit_r, a1_hit_nxt;
	logic a2_hit_r, a2_hit_nxt;
	logic [2:0] st1_user_r, st1_user_nxt;
	logic [7:0] st2_r, st2_nxt;
	logic [23:0] alm1_r, alm1_nxt;
	logic [23:0] alm2_r, alm2_nxt;
	logic [7:0] trim_r, trim_nxt;
	logic [7:0] scr_r, scr_nxt;

	// Alarm pin latches and outputs
	logic a1_low_r, a1_low_nxt;
	logic a2_low_r, a2_low_nxt;
	logic oe_r, oe_nxt;
	logic [23:0] rdata_r, rdata_nxt;
	logic preset_r, preset_nxt;

	// Combinational decode
	logic freq_mode, a1_mode, a2_en;
	logic [NFREQ-1:0] freq_sel, freq_lvl;
	logic freq_and, freq_low;
	logic a1_fire, a2_fire, init_wr;
	logic [7:0] st1_view;
	logic a1_drive, a2_drive;

	function automatic logic field_eq(input logic [7:0] a, input logic [7:0] b,
			input logic [7:0] m);
		field_eq = ((a ^ b) & m) == 8'h00;
	endfunction

	// All enabled fields equal; no field enabled never matches
	function automatic logic alarm_match(input logic [23:0] a, input logic [23:0] now);
		logic wk_en, hr_en, mn_en;
		wk_en = a[`RAFO_WK_HI-7+`RAFO_FLD_EN];
		hr_en = a[`RAFO_HR_HI-7+`RAFO_FLD_EN];
		mn_en = a[`RAFO_MN_HI-7+`RAFO_FLD_EN];
		// Each field compares only its value bits; bit 0 is the enable itself
		alarm_match = (wk_en | hr_en | mn_en)
			& (~wk_en | field_eq(a[23:16], now[23:16], `RAFO_WK_MASK))
			& (~hr_en | field_eq(a[15:8], now[15:8], `RAFO_HR_MASK))
			& (~mn_en | field_eq(a[7:0], now[7:0], `RAFO_MN_MASK));
	endfunction

	// Divider taps, one per frequency-select bit
	genvar gi;
	generate
		for (gi = 0; gi < NFREQ; gi = gi + 1) begin : g_freq
			assign freq_lvl[gi] = presc_r[FREQ_TAPS[4*gi +: 4]];
		end
	endgenerate

	always_comb begin
		// Minute-edge, minute-periodic and crystal modes are not built; only alarm 2 can drive the pin there
		freq_mode = ~st2_r[`RAFO_ST2_CRYS] & ~st2_r[`RAFO_ST2_MINIRQ]
			& st2_r[`RAFO_ST2_FREQ];
		a1_mode = ~st2_r[`RAFO_ST2_CRYS] & st2_r[`RAFO_ST2_A1EN]
			& ~st2_r[`RAFO_ST2_MINIRQ] & ~st2_r[`RAFO_ST2_FREQ];
		a2_en = st2_r[`RAFO_ST2_A2EN];
		// Frequency byte lives in the first (weekday) lane of the register
		freq_sel = alm1_r[16+`RAFO_FSEL_HI : 16+`RAFO_FSEL_LO];
		// Unselected bits count as high, so the AND sees only selected ones
		freq_and = &(freq_lvl | ~freq_sel);
		freq_low = freq_mode & (|freq_sel) & ~freq_and;
		// Alarms are judged only on the minute tick, so a re-enable mid-match waits
		a1_fire = i_minute_tick & a1_mode & alarm_match(alm1_r, i_now_wkhm);
		a2_fire = i_minute_tick & a2_en & alarm_match(alm2_r, i_now_wkhm);
		init_wr = i_reg_wr & (i_reg_sel == RAFO_SEL_STATUS1)
			& i_reg_wdata[`RAFO_ST1_INIT];
		st1_view = 8'h00;
		st1_view[`RAFO_ST1_PWRUP] = pwrup_r;
		st1_view[`RAFO_ST1_A2HIT] = a2_hit_r;
		st1_view[`RAFO_ST1_A1HIT] = a1_hit_r;
		st1_view[`RAFO_ST1_USER_HI:`RAFO_ST1_USER_LO] = st1_user_r;
		// Low-voltage detector sits outside this block; its flag reads 0
		st1_view[`RAFO_ST1_LOWV] = 1'b0;
		// Initialization bit is write-only and always reads 0
		st1_view[`RAFO_ST1_INIT] = 1'b0;
	end

	// Prescaler counts oscillator edges; wrap is the second increment
	always_comb begin
		// Initialization never clears the prescaler, so seconds keep their phase
		presc_nxt = presc_r;
		sec_tick_nxt = 1'b0;
		if (osc_s2_r & ~osc_s3_r) begin
			presc_nxt = presc_r + {{(PW-1){1'b0}}, 1'b1};
			// Top tap falls exactly here, so the 1 Hz edge meets the carry
			sec_tick_nxt = &presc_r;
		end
	end

	always_comb begin
		pwrup_nxt = pwrup_r;
		a1_hit_nxt = a1_hit_r;
		a2_hit_nxt = a2_hit_r;
		st1_user_nxt = st1_user_r;
		st2_nxt = st2_r;
		alm1_nxt = alm1_r;
		alm2_nxt = alm2_r;
		trim_nxt = trim_r;
		scr_nxt = scr_r;
		a1_low_nxt = a1_low_r;
		a2_low_nxt = a2_low_r;
		preset_nxt = 1'b0;
		rdata_nxt = rdata_r;

		// Read and write in one cycle: the read returns the old contents
		if (i_reg_rd) begin
			case (i_reg_sel)
				RAFO_SEL_STATUS1: begin
					rdata_nxt = {16'h0000, st1_view};
					pwrup_nxt = 1'b0;
					a1_hit_nxt = 1'b0;
					a2_hit_nxt = 1'b0;
				end
				RAFO_SEL_STATUS2: rdata_nxt = {16'h0000, st2_r};
				RAFO_SEL_ALARM1: rdata_nxt = alm1_r;
				RAFO_SEL_ALARM2: rdata_nxt = alm2_r;
				RAFO_SEL_TRIM: rdata_nxt = {16'h0000, trim_r};
				RAFO_SEL_SCRATCH: rdata_nxt = {16'h0000, scr_r};
				default: rdata_nxt = 24'h000000;
			endcase
		end

		if (i_reg_wr) begin
			case (i_reg_sel)
				RAFO_SEL_STATUS1: begin
					st1_user_nxt = i_reg_wdata[`RAFO_ST1_USER_HI:`RAFO_ST1_USER_LO];
				end
				RAFO_SEL_STATUS2: st2_nxt = i_reg_wdata[7:0];
				// Whole word stored; scratch bits of the frequency byte only read back
				RAFO_SEL_ALARM1: alm1_nxt = i_reg_wdata;
				RAFO_SEL_ALARM2: alm2_nxt = i_reg_wdata;
				RAFO_SEL_TRIM: trim_nxt = i_reg_wdata[7:0];
				RAFO_SEL_SCRATCH: scr_nxt = i_reg_wdata[7:0];
				default: ;
			endcase
		end

		// Initialization keeps the written format and user bits
		if (init_wr) begin
			pwrup_nxt = 1'b0;
			a1_hit_nxt = 1'b0;
			a2_hit_nxt = 1'b0;
			st2_nxt = `RAFO_ST2_INIT;
			alm1_nxt = `RAFO_ALM_INIT;
			alm2_nxt = `RAFO_ALM_INIT;
			trim_nxt = `RAFO_BYTE_INIT;
			scr_nxt = `RAFO_BYTE_INIT;
			preset_nxt = 1'b1;
		end

		// Latches release as soon as the alarm is switched off
		if (!a1_mode) begin
			a1_low_nxt = 1'b0;
		end
		if (!a2_en) begin
			a2_low_nxt = 1'b0;
		end

		// A hit in the clearing cycle is kept: set wins
		if (a1_fire) begin
			a1_hit_nxt = 1'b1;
			a1_low_nxt = 1'b1;
		end
		if (a2_fire) begin
			a2_hit_nxt = 1'b1;
			a2_low_nxt = 1'b1;
		end

		// Each alarm latch is gated by its own enable, so both release in step
		// with the frequency output when the mode bits are written
		a1_drive = a1_mode & a1_low_r;
		a2_drive = a2_en & a2_low_r;
		// Pin drives low for either register's output
		oe_nxt = a2_drive | a1_drive | freq_low;
	end

	always_ff @(posedge i_sys_clk) begin
		// Two stages settle the pin; the third only feeds the edge detector
		osc_s1_r <= i_osc_clk;
		osc_s2_r <= osc_s1_r;
		osc_s3_r <= osc_s2_r;
		if (i_rst) begin
			presc_r <= '0;
			sec_tick_r <= 1'b0;
			pwrup_r <= 1'b1;
			a1_hit_r <= 1'b0;
			a2_hit_r <= 1'b0;
			st1_user_r <= 3'h0;
			st2_r <= `RAFO_ST2_POR;
			alm1_r <= `RAFO_ALM1_POR;
			alm2_r <= `RAFO_ALM2_POR;
			trim_r <= `RAFO_TRIM_POR;
			scr_r <= `RAFO_SCR_POR;
			a1_low_r <= 1'b0;
			a2_low_r <= 1'b0;
			oe_r <= 1'b0;
			rdata_r <= 24'h000000;
			preset_r <= 1'b1;
		end else begin
			presc_r <= presc_nxt;
			sec_tick_r <= sec_tick_nxt;
			pwrup_r <= pwrup_nxt;
			a1_hit_r <= a1_hit_nxt;
			a2_hit_r <= a2_hit_nxt;
			st1_user_r <= st1_user_nxt;
			st2_r <= st2_nxt;
			alm1_r <= alm1_nxt;
			alm2_r <= alm2_nxt;
			trim_r <= trim_nxt;
			scr_r <= scr_nxt;
			a1_low_r <= a1_low_nxt;
			a2_low_r <= a2_low_nxt;
			oe_r <= oe_nxt;
			rdata_r <= rdata_nxt;
			preset_r <= preset_nxt;
		end
	end

	// Open-drain: the data flop is held low, only the enable moves
	logic pin_o_r;
	logic [55:0] preset_time_r;
	always_ff @(posedge i_sys_clk) begin
		pin_o_r <= 1'b0;
		preset_time_r <= `RAFO_RT_DEFAULT;
	end

	assign o_reg_rdata = rdata_r;
	assign o_irq_pin_o = pin_o_r;
	assign o_irq_pin_oe = oe_r;
	assign o_second_tick = sec_tick_r;
	assign o_hour24 = st1_user_r[2];
	// Trim feeds the rate-correction arithmetic outside; 00h means none
	assign o_rate_trim = trim_r;
	// The calendar loads o_preset_time while this strobe is high
	assign o_preset_stb = preset_r;
	assign o_preset_time = preset_time_r;

endmodule

// *** verilog/rafo_cfg.svh ***
// Offsets, field positions, reset values and divider taps of the
// alarm / frequency-output block.
// Assumes inclusion by bare name from files under verilog/ and bench/.
`ifndef RAFO_CFG_SVH
`define RAFO_CFG_SVH

// Oscillator divider chain
`define RAFO_OSC_HZ 32768
`define RAFO_PRESC_W 15
// Divider tap per frequency-select bit, B3 in the low nibble, B7 in the high
`define RAFO_FREQ_TAPS 20'hEDCBA

// Byte lanes of a 3-byte alarm register (weekday first)
`define RAFO_WK_HI 23
`define RAFO_HR_HI 15
`define RAFO_MN_HI 7
// Field-enable bit inside each alarm byte
`define RAFO_FLD_EN 0
// Meaningful bits of each alarm byte for the match
`define RAFO_WK_MASK 8'hE0
`define RAFO_HR_MASK 8'hFE
`define RAFO_MN_MASK 8'hFE
// Frequency-select field inside the first byte of the first register
`define RAFO_FSEL_HI 7
`define RAFO_FSEL_LO 3

// First status register
`define RAFO_ST1_PWRUP 0
`define RAFO_ST1_LOWV 1
`define RAFO_ST1_A2HIT 2
`define RAFO_ST1_A1HIT 3
`define RAFO_ST1_USER_LO 4
`define RAFO_ST1_USER_HI 6
`define RAFO_ST1_INIT 7

// Second status register
`define RAFO_ST2_A2EN 1
`define RAFO_ST2_CRYS 4
`define RAFO_ST2_A1EN 5
`define RAFO_ST2_MINIRQ 6
`define RAFO_ST2_FREQ 7

// Power-on values
`define RAFO_ST2_POR 8'h80
`define RAFO_ALM1_POR 24'h800000
`define RAFO_ALM2_POR 24'h000000
`define RAFO_TRIM_POR 8'h00
`define RAFO_SCR_POR 8'h00
// Initialization values
`define RAFO_ST2_INIT 8'h00
`define RAFO_ALM_INIT 24'h000000
`define RAFO_BYTE_INIT 8'h00
// Time of day: year, month, day, weekday, hour, minute, second
`define RAFO_RT_DEFAULT 56'h00808000000000

`endif

// *** verilog/rafo_pkg.sv ***
// Types shared by the alarm / frequency-output block.
// Assumes nothing of its surroundings.
package rafo_pkg;

	typedef enum logic [2:0] {
		RAFO_SEL_STATUS1,
		RAFO_SEL_STATUS2,
		RAFO_SEL_ALARM1,
		RAFO_SEL_ALARM2,
		RAFO_SEL_TRIM,
		RAFO_SEL_SCRATCH
	} rafo_reg_sel_t;

endpackage
